// *** src/tpt_host.sv ***
// host controller: programs trigger units within limits, drives timestamp pin
`timescale 1ns/100ps
// How it works
// - cascaded pulse/periodic unit starts spaced at least 120 ns.
// - cascaded edge/shift unit starts spaced at least 80 ns.
// - cascaded single-pulse cycle at least 80 ns and 32 ns plus width.
// - cascaded periodic cycle time at least 80 ns.
// - cascaded pulses: 80 ns from first period end to next output.
// - cascaded pulse width at least 8 ns.
// - uncascaded cycle at least 80 ns and 32 ns plus width.
// - uncascaded gap between pulses at least 32 ns.
// - uncascaded pulse width at least 8 ns.
// - timestamp input waveform high for at least 24 ns.
module tpt_host #(
  parameter int NUM_UNITS = tpt_pkg::NUM_UNITS
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // trigger programming request
  input  wire logic                       req_valid,
  input  wire logic [tpt_pkg::UNIT_W-1:0] req_unit,
  input  wire logic [2:0]                 req_mode,
  input  wire logic                       req_cascade,
  input  wire logic [tpt_pkg::CNT_W-1:0]  req_width,
  input  wire logic [tpt_pkg::CNT_W-1:0]  req_cycle,
  output logic                            req_ready,
  output logic                            req_reject,
  // trigger programming toward the device
  output logic                            cfg_strobe,
  output logic [tpt_pkg::UNIT_W-1:0]      cfg_unit,
  output logic [tpt_pkg::CFG_W-1:0]       trigger_unit_config_word,
  output logic [tpt_pkg::CNT_W-1:0]       cfg_width,
  output logic [tpt_pkg::CNT_W-1:0]       cfg_cycle,
  // timestamp stimulus pin request
  input  wire logic                       ts_req,
  input  wire logic [tpt_pkg::CNT_W-1:0]  ts_high,
  input  wire logic [tpt_pkg::CNT_W-1:0]  ts_low,
  output logic                            ts_busy,
  output logic                            ts_pin,
  // trigger pin returned by the device
  input  wire logic                       trig_pin,
  output logic                            trig_level
);

  localparam logic [tpt_pkg::CNT_W-1:0] CYC_MIN =
    tpt_pkg::CNT_W'(tpt_pkg::MIN_CYCLE_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] OVER_PW =
    tpt_pkg::CNT_W'(tpt_pkg::CYCLE_OVER_PW_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] PW_CAS =
    tpt_pkg::CNT_W'(tpt_pkg::CAS_MIN_PW_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] PW_SGL =
    tpt_pkg::CNT_W'(tpt_pkg::SGL_MIN_PW_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] GAP_CAS =
    tpt_pkg::CNT_W'(tpt_pkg::CAS_GAP_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] GAP_SGL =
    tpt_pkg::CNT_W'(tpt_pkg::SGL_GAP_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] SP_PULSE =
    tpt_pkg::CNT_W'(tpt_pkg::CAS_START_PULSE_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] SP_EDGE =
    tpt_pkg::CNT_W'(tpt_pkg::CAS_START_EDGE_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] TSH_MIN =
    tpt_pkg::CNT_W'(tpt_pkg::TS_HIGH_CYC);
  localparam logic [tpt_pkg::CNT_W-1:0] TSL_MIN =
    tpt_pkg::CNT_W'(tpt_pkg::TS_LOW_CYC);
  localparam logic [tpt_pkg::CNT_W:0]   TSC_MIN =
    (tpt_pkg::CNT_W+1)'(tpt_pkg::TS_CYCLE_CYC);

  // widened sum so a large width cannot wrap past the cycle check
  function automatic logic [tpt_pkg::CNT_W:0] add_w(
    input logic [tpt_pkg::CNT_W-1:0] a,
    input logic [tpt_pkg::CNT_W-1:0] b
  );
    add_w = {1'b0, a} + {1'b0, b};
  endfunction

  // mode classes
  wire mode_pulse  = (req_mode == tpt_pkg::MODE_NEG_PULSE) ||
                     (req_mode == tpt_pkg::MODE_POS_PULSE);
  wire mode_period = (req_mode == tpt_pkg::MODE_NEG_PER) ||
                     (req_mode == tpt_pkg::MODE_POS_PER);
  wire mode_shift  = (req_mode == tpt_pkg::MODE_SHIFT);
  wire mode_known  = mode_pulse || mode_period || mode_shift;

  // limit checks on the requested programming
  wire [tpt_pkg::CNT_W-1:0] pw_min = req_cascade ? PW_CAS : PW_SGL;
  wire width_ok  = req_width >= pw_min;
  wire cyc80_ok  = req_cycle >= CYC_MIN;
  wire cycpw_ok  = {1'b0, req_cycle} >= add_w(OVER_PW, req_width);
  // gap after the pulse inside one cycle
  wire [tpt_pkg::CNT_W-1:0] gap_min = req_cascade ? GAP_CAS : GAP_SGL;
  wire gap_ok    = !mode_pulse ||
                   ({1'b0, req_cycle} >= add_w(gap_min, req_width));
  wire cyc_ok    = cyc80_ok && (!(mode_pulse || !req_cascade) || cycpw_ok);
  wire unit_ok   = req_unit < tpt_pkg::UNIT_W'(NUM_UNITS);
  wire params_ok = mode_known && unit_ok && width_ok && cyc_ok && gap_ok;

  // spacing required before the next cascaded start
  wire [tpt_pkg::CNT_W-1:0] next_space =
    (mode_pulse || mode_period) ? SP_PULSE : SP_EDGE;
  logic [tpt_pkg::CNT_W-1:0] space_cnt;
  wire space_busy = req_cascade && (space_cnt != '0);
  wire take       = req_valid && req_ready && !space_busy;
  wire accept     = take && params_ok;
  wire refuse     = take && !params_ok;
  wire [tpt_pkg::CNT_W-1:0] next_space_cnt =
    accept ? next_space - tpt_pkg::CNT_W'(1) :
    (space_cnt != '0) ? space_cnt - tpt_pkg::CNT_W'(1) : space_cnt;
  // config word: mode in its field, other bits zero
  wire [tpt_pkg::CFG_W-1:0] next_word =
    tpt_pkg::CFG_W'({req_mode, tpt_pkg::MODE_LSB'(0)});

  // programming outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      space_cnt                <= '0;
      cfg_strobe               <= 1'b0;
      cfg_unit                 <= '0;
      trigger_unit_config_word <= '0;
      cfg_width                <= '0;
      cfg_cycle                <= '0;
      req_reject               <= 1'b0;
      req_ready                <= 1'b0;
    end else begin
      space_cnt  <= next_space_cnt;
      cfg_strobe <= accept;
      req_reject <= refuse;
      req_ready  <= 1'b1;
      if (accept) begin
        cfg_unit                 <= req_unit;
        trigger_unit_config_word <= next_word;
        cfg_width                <= req_width;
        cfg_cycle                <= req_cycle;
      end
    end
  end

  // timestamp stimulus: high then low, both clamped to the minimum
  tpt_pkg::tpt_drive_e      ts_state;
  tpt_pkg::tpt_drive_e      next_ts_state;
  logic [tpt_pkg::CNT_W-1:0] ts_cnt;
  logic [tpt_pkg::CNT_W-1:0] next_ts_cnt;
  logic [tpt_pkg::CNT_W-1:0] low_len;
  wire [tpt_pkg::CNT_W-1:0] hi_use = (ts_high < TSH_MIN) ? TSH_MIN : ts_high;
  wire [tpt_pkg::CNT_W-1:0] lo_fit = (ts_low < TSL_MIN) ? TSL_MIN : ts_low;
  // stretch low so the whole period meets its minimum
  wire [tpt_pkg::CNT_W-1:0] lo_use =
    (add_w(hi_use, lo_fit) < TSC_MIN) ?
    tpt_pkg::CNT_W'(TSC_MIN - {1'b0, hi_use}) : lo_fit;
  wire ts_start = ts_req && (ts_state == tpt_pkg::TPT_IDLE);
  wire cnt_done = (ts_cnt == tpt_pkg::CNT_W'(1));

  // next-state decode for the timestamp pin
  always_comb begin
    next_ts_state = ts_state;
    next_ts_cnt   = (ts_cnt != '0) ? ts_cnt - tpt_pkg::CNT_W'(1) : ts_cnt;
    unique case (ts_state)
      tpt_pkg::TPT_IDLE: begin
        if (ts_start) begin
          next_ts_state = tpt_pkg::TPT_HIGH;
          next_ts_cnt   = hi_use;
        end
      end
      tpt_pkg::TPT_HIGH: begin
        if (cnt_done) begin
          next_ts_state = tpt_pkg::TPT_LOW;
          next_ts_cnt   = low_len;
        end
      end
      tpt_pkg::TPT_LOW: begin
        if (cnt_done) begin
          next_ts_state = tpt_pkg::TPT_IDLE;
        end
      end
    endcase
  end

  // timestamp state and pin registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ts_state <= tpt_pkg::TPT_IDLE;
      ts_cnt   <= '0;
      low_len  <= '0;
      ts_pin   <= 1'b0;
      ts_busy  <= 1'b0;
    end else begin
      ts_state <= next_ts_state;
      ts_cnt   <= next_ts_cnt;
      if (ts_start) begin
        low_len <= lo_use;
      end
      ts_pin  <= (next_ts_state == tpt_pkg::TPT_HIGH);
      ts_busy <= (next_ts_state != tpt_pkg::TPT_IDLE);
    end
  end

  // trigger pin is asynchronous: two flops before use
  logic trig_meta;
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trig_meta  <= 1'b0;
      trig_level <= 1'b0;
    end else begin
      trig_meta  <= trig_pin;
      trig_level <= trig_meta;
    end
  end

endmodule

// *** src/tpt_pkg.sv ***
// constants shared by the trigger/timestamp host controller
package tpt_pkg;
  // clock period in ps (100 MHz)
  localparam int CLK_PS           = 10000;
  // trigger output-mode field of the unit config word
  localparam int MODE_LSB         = 4;
  localparam int MODE_MSB         = 6;
  localparam logic [2:0] MODE_NEG_PULSE = 3'h2;
  localparam logic [2:0] MODE_POS_PULSE = 3'h3;
  localparam logic [2:0] MODE_NEG_PER   = 3'h4;
  localparam logic [2:0] MODE_POS_PER   = 3'h5;
  localparam logic [2:0] MODE_SHIFT     = 3'h6;
  localparam int CFG_W            = 8;
  localparam int UNIT_W           = 4;
  localparam int NUM_UNITS        = 12;
  // timing limits in ns
  localparam int CAS_START_PULSE_NS = 120;
  localparam int CAS_START_EDGE_NS  = 80;
  localparam int MIN_CYCLE_NS       = 80;
  localparam int CYCLE_OVER_PW_NS   = 32;
  localparam int CAS_GAP_NS         = 80;
  localparam int CAS_MIN_PW_NS      = 8;
  localparam int SGL_GAP_NS         = 32;
  localparam int SGL_MIN_PW_NS      = 8;
  localparam int TS_HIGH_NS         = 24;
  localparam int TS_LOW_NS          = 24;
  localparam int TS_CYCLE_NS        = 48;
  // least times round up to whole cycles
  localparam int CAS_START_PULSE_CYC = (CAS_START_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CAS_START_EDGE_CYC  = (CAS_START_EDGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int MIN_CYCLE_CYC       = (MIN_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CYCLE_OVER_PW_CYC   = (CYCLE_OVER_PW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CAS_GAP_CYC         = (CAS_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CAS_MIN_PW_CYC      = (CAS_MIN_PW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SGL_GAP_CYC         = (SGL_GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SGL_MIN_PW_CYC      = (SGL_MIN_PW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TS_HIGH_CYC         = (TS_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TS_LOW_CYC          = (TS_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TS_CYCLE_CYC        = (TS_CYCLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W               = 16;
  typedef enum logic [1:0] {TPT_IDLE, TPT_HIGH, TPT_LOW} tpt_drive_e;
endpackage

// *** testbench/tpt_dev_model.sv ***
// behavioural device: twelve trigger units sharing one output pin
`timescale 1ns/100ps
module tpt_dev_model (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // unit programming
  input wire logic        cfg_strobe,
  input wire logic [3:0]  cfg_unit,
  input wire logic [7:0]  cfg_word,
  input wire logic [15:0] cfg_width,
  // shared pin
  output logic            trig_pin
);
  logic [2:0]  mode [12];
  logic [15:0] left;
  logic        pos;
  // newest unit owns the pin only for its active width, then idles
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      left <= 16'h0000;
      pos <= 1'b1;
      trig_pin <= 1'b0;
    end else if (cfg_strobe && cfg_unit < 4'hc) begin
      mode[cfg_unit] <= cfg_word[6:4];
      pos <= cfg_word[4] || cfg_word[6:4] == 3'h6;
      left <= cfg_width;
    end else if (left != 16'h0000) begin
      trig_pin <= pos;
      left <= left - 16'h0001;
    end else
      trig_pin <= !pos;
  end
endmodule

// *** testbench/tpt_host_checker.sv ***
// port checks for the trigger and stamp host controller
`timescale 1ns/100ps
module tpt_host_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // programming
  input wire logic        req_valid,
  input wire logic [3:0]  req_unit,
  input wire logic        req_cascade,
  input wire logic        req_ready,
  input wire logic        req_reject,
  input wire logic        cfg_strobe,
  input wire logic [7:0]  trigger_unit_config_word,
  input wire logic [15:0] cfg_width,
  input wire logic [15:0] cfg_cycle,
  // pins
  input wire logic        ts_req,
  input wire logic        ts_busy,
  input wire logic        ts_pin,
  input wire logic        trig_pin,
  input wire logic        trig_level
);
  logic [7:0] since;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // edges since the last accept, saturating so long idles stay quiet
  always_ff @(posedge sys_clk) begin
    if (!rst_b)
      since <= 8'hff;
    else if (cfg_strobe)
      since <= 8'h02;
    else if (since != 8'hff)
      since <= since + 8'h01;
  end
  sequence hi3_s; ts_pin [*3]; endsequence
  sequence lo3_s; !ts_pin [*3]; endsequence
  one_answer_a: assert property (
    req_valid && req_ready && !req_cascade |=> cfg_strobe != req_reject)
    else $error("request without single answer");
  unit_range_a: assert property (
    req_valid && req_ready && !req_cascade && req_unit > 4'hb |=> req_reject)
    else $error("unit index out of range accepted");
  mode_field_a: assert property (
    cfg_strobe |-> trigger_unit_config_word[6:4] inside {[3'h2:3'h6]}
    && trigger_unit_config_word[7] == 1'b0 && trigger_unit_config_word[3:0] == 4'h0)
    else $error("bad mode field");
  width_min_a: assert property (cfg_strobe |-> cfg_width != 16'h0000)
    else $error("zero pulse width sent");
  cycle_min_a: assert property (cfg_strobe |-> cfg_cycle >= 16'h0008)
    else $error("cycle below minimum sent");
  cas_space_a: assert property (
    req_valid && req_cascade && (cfg_strobe || since < 8'h08) |=> !cfg_strobe && !req_reject)
    else $error("cascaded start too close");
  ts_start_a: assert property (ts_req && !ts_busy |=> ts_pin && ts_busy)
    else $error("stamp period not started");
  ts_high_a: assert property ($rose(ts_pin) |-> hi3_s)
    else $error("stamp high too short");
  ts_low_a: assert property ($fell(ts_pin) |-> lo3_s)
    else $error("stamp low too short");
  trig_sync_a: assert property (trig_level == $past(trig_pin, 2))
    else $error("trigger level not two edges behind pin");
endmodule
bind tpt_host tpt_host_checker chk (.sys_clk, .rst_b, .req_valid, .req_unit, .req_cascade,
  .req_ready, .req_reject, .cfg_strobe, .trigger_unit_config_word, .cfg_width, .cfg_cycle,
  .ts_req, .ts_busy, .ts_pin, .trig_pin, .trig_level);

// *** testbench/tpt_host_test.sv ***
// self-checking bench for the trigger and stamp host controller
`timescale 1ns/100ps
module tpt_host_test;
  logic        sys_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_cascade = 1'b0;
  logic        ts_req = 1'b0, req_ready, req_reject, cfg_strobe, ts_busy, ts_pin;
  logic        trig_pin, trig_level;
  logic [3:0]  req_unit = 4'h0, cfg_unit;
  logic [2:0]  req_mode = 3'h0;
  logic [7:0]  trigger_unit_config_word;
  logic [15:0] req_width = 16'h0000, req_cycle = 16'h0000, ts_high = 16'h0000;
  logic [15:0] ts_low = 16'h0000, cfg_width, cfg_cycle;
  int          fails = 0, num_checks = 0, cyc = 0, n, i, k;
  tpt_host #(.NUM_UNITS(12)) dut (.sys_clk, .rst_b, .req_valid, .req_unit, .req_mode,
    .req_cascade, .req_width, .req_cycle, .req_ready, .req_reject, .cfg_strobe, .cfg_unit,
    .trigger_unit_config_word, .cfg_width, .cfg_cycle, .ts_req, .ts_high, .ts_low,
    .ts_busy, .ts_pin, .trig_pin, .trig_level);
  tpt_dev_model dev (.sys_clk, .rst_b, .cfg_strobe, .cfg_unit,
    .cfg_word(trigger_unit_config_word), .cfg_width, .trig_pin);
  always #5 sys_clk = ~sys_clk;
  // hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  function automatic logic lim_ok(logic [3:0] u, logic [2:0] m, logic c, logic [15:0] w, y);
    lim_ok = u < 4'hc && m >= 3'h2 && m <= 3'h6 && w != 0 && y >= 16'h0008;
    if ((m < 3'h4 || !c) && y < w + 16'h0004) lim_ok = 1'b0;
    if (m < 3'h4 && c && y < w + 16'h0008) lim_ok = 1'b0;
  endfunction
  task automatic chk(logic [63:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, held while a cascaded start may be held off by the spacing
  task automatic req(logic [3:0] u, logic [2:0] m, logic c, logic [15:0] w, y);
    {req_unit, req_mode, req_cascade, req_width, req_cycle} <= {u, m, c, w, y};
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      if (!c) req_valid <= 1'b0;
      #1 n++;
    end while (!(cfg_strobe || req_reject) && n < 40);
    // a held cascaded request is dropped and one edge passes before the next
    if (c) begin
      req_valid <= 1'b0;
      @(posedge sys_clk);
      #1;
    end
    chk(cfg_strobe === 1'b1 || !c ? cfg_strobe : 1'b0, c ? 1'b0 : lim_ok(u, m, c, w, y));
    chk(req_reject, c ? 1'b0 : !lim_ok(u, m, c, w, y));
    if (lim_ok(u, m, c, w, y))
      chk({cfg_unit, trigger_unit_config_word, cfg_width, cfg_cycle},
          {u, 1'b0, m, 4'h0, w, y});
  endtask
  // one stamp period, measuring its high and low lengths
  task automatic stamp(logic [15:0] h, l);
    {ts_high, ts_low, ts_req} <= {h, l, 1'b1};
    @(posedge sys_clk);
    ts_req <= 1'b0;
    // pin rises on the taking edge; look once it has settled
    #1;
    for (k = 0; ts_pin === 1'b1 && k < 99; k++) @(posedge sys_clk) #1;
    chk(k, h < 3 ? 3 : h);
    for (k = 0; ts_busy === 1'b1 && k < 99; k++) @(posedge sys_clk) #1;
    chk(k, l < 3 ? 3 : l);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(36));
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 req(4'hb, 3'h3, 1'b0, 16'h0001, 16'h0008);
    req(4'hc, 3'h2, 1'b0, 16'h0001, 16'h0008);
    req(4'h0, 3'h2, 1'b0, 16'h0000, 16'h0008);
    req(4'h1, 3'h5, 1'b0, 16'h0004, 16'h0007);
    req(4'h2, 3'h2, 1'b0, 16'h0005, 16'h0009);
    req(4'h2, 3'h2, 1'b0, 16'h0006, 16'h0009);
    for (i = 0; i < 8; i++) req(4'h3, i[2:0], 1'b0, 16'h0002, 16'h0010);
    $display("corner test done");
    for (i = 0; i < 60; i++)
      req(4'($urandom % 13), 3'($urandom), 1'($urandom), 16'($urandom % 12),
          16'($urandom % 24));
    $display("random test done");
    // back-to-back cascaded starts are spaced per mode class
    for (i = 2; i < 7; i++) begin
      repeat (20) @(posedge sys_clk);
      #1 chk(trig_level, trig_pin);
      req(4'h4, i[2:0], 1'b1, 16'h0002, 16'h0014);
      req(4'h5, i[2:0], 1'b1, 16'h0002, 16'h0014);
      // one edge of the spacing is spent between the two calls
      chk(n, (i == 6 ? 8 : 12) - 1);
    end
    $display("cascade test done");
    stamp(16'h0001, 16'h0001);
    for (i = 0; i < 4; i++) stamp(16'($urandom % 9), 16'($urandom % 9));
    $display("stamp test done");
    complete_run();
  end
endmodule
